// *** rtl/lbsc_bus_ctrl.sv ***
// Local bus status and control: cycle sequencer, strobes, queue status pins.
// Assumes the core drives requests on i_clk; pins are synchronised here.
`timescale 1ns/1ps
module lbsc_bus_ctrl import lbsc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic [2:0] i_req_status,
  input wire logic [19:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic i_req_word,
  input wire logic i_req_refresh,
  input wire logic i_req_lock,
  input wire logic i_bus16,
  input wire logic i_ignore_ready,
  input wire logic i_instr_boundary,
  input wire queue_op_t i_queue_op,
  output logic o_req_ready,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_queue_mode,
  input wire logic i_async_ready,
  input wire logic i_sync_ready,
  input wire logic i_hold,
  input wire logic [15:0] i_ad_in,
  output logic [15:0] o_ad_out,
  output logic o_ad_oe,
  output logic [3:0] o_addr_hi,
  output logic o_addr_hi_oe,
  output logic [2:0] o_bus_cycle_status,
  output logic o_status_oe,
  output logic o_ale_queue_state_low,
  output logic o_wr_n_queue_state_high,
  output logic o_wr_oe,
  input wire logic i_rd_queue_mode_select,
  output logic o_rd_n,
  output logic o_rd_oe,
  output logic o_upper_byte_enable_n,
  output logic o_ube_oe,
  output logic o_transceiver_data_enable_n,
  output logic o_den_oe,
  output logic o_lock_n,
  output logic o_lock_oe,
  output logic o_bus_grant_ack,
  output logic o_bus_clock_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_state_t st;
    logic [1:0] strap_cnt;
    logic mode_done;
    logic qmode;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic den_n;
    logic lock;
    logic [2:0] status;
    logic [15:0] ad_out;
    logic ad_oe;
    logic [3:0] ahi;
    logic ube_n;
    logic [1:0] qs;
    logic rdy_seen;
    logic grant;
    logic done;
    logic [15:0] rdata;
    logic write;
    logic readlike;
    logic refresh;
  } ctrl_t;

  ctrl_t s_r;
  ctrl_t s_nxt;
  logic rise;
  logic fall;
  logic async_ready_s;
  logic sync_ready_s;
  logic hold_s;
  logic rd_s;
  logic [15:0] ad_s;
  logic grant_ok;

  // ----------------------------------------------------------------
  // Clock and pin synchronisers
  // ----------------------------------------------------------------
  lbsc_clk_div u_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_bus_clock_out(o_bus_clock_out),
    .o_rise_en(rise),
    .o_fall_en(fall)
  );

  lbsc_sync2 #(.W(4), .RST({LINE_RST, LINE_RST, LINE_RST, STRAP_RST})) u_sync_ctl (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({i_async_ready, i_sync_ready, i_hold, i_rd_queue_mode_select}),
    .o_q({async_ready_s, sync_ready_s, hold_s, rd_s})
  );

  lbsc_sync2 #(.W(AD_W), .RST('0)) u_sync_ad (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_ad_in),
    .o_q(ad_s)
  );

  // Lock blocks the grant so a locked sequence cannot be split
  assign grant_ok = hold_s && i_instr_boundary && !s_r.lock;
  assign o_req_ready = rise && (s_r.st == S_IDLE) && s_r.mode_done && !grant_ok;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    // Strap waits for the synchroniser to see the real pin level
    if (!s_r.mode_done) begin
      if (s_r.strap_cnt == STRAP_WAIT) begin
        s_nxt.mode_done = 1'b1;
        s_nxt.qmode = ~rd_s;
      end else begin
        s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      end
    end
    unique case (i_queue_op)
      Q_OP_NONE: s_nxt.qs = QS_NONE;
      Q_OP_FIRST: s_nxt.qs = QS_FIRST;
      Q_OP_NEXT: s_nxt.qs = QS_NEXT;
      Q_OP_EMPTY: s_nxt.qs = QS_EMPTY;
    endcase
    if (fall) begin
      s_nxt.ale = 1'b0;
      if (s_r.st == S_T3 && (async_ready_s || sync_ready_s)) begin
        s_nxt.rdy_seen = 1'b1;
      end
    end
    if (rise) begin
      unique case (s_r.st)
        S_IDLE: begin
          if (s_r.mode_done && grant_ok) begin
            s_nxt.st = S_HOLD;
            s_nxt.grant = 1'b1;
          end else if (s_r.mode_done && i_req) begin
            s_nxt.st = S_T1;
            s_nxt.status = i_req_status;
            s_nxt.ale = 1'b1;
            s_nxt.ad_out = i_req_addr[15:0];
            s_nxt.ad_oe = 1'b1;
            s_nxt.ahi = i_req_addr[19:16];
            s_nxt.lock = i_req_lock;
            s_nxt.refresh = i_req_refresh;
            s_nxt.write = (i_req_status == ST_IO_WR) || (i_req_status == ST_MEM_WR);
            s_nxt.readlike = (i_req_status == ST_INTA) || (i_req_status == ST_IO_RD) ||
              (i_req_status == ST_FETCH) || (i_req_status == ST_MEM_RD);
            if (!i_bus16) begin
              s_nxt.ube_n = ~i_req_refresh;
            end else if (i_req_refresh) begin
              s_nxt.ad_out[0] = 1'b1;
              s_nxt.ube_n = 1'b1;
            end else begin
              s_nxt.ube_n = ~(i_req_word | i_req_addr[0]);
            end
          end
        end
        S_T1: begin
          s_nxt.ahi = 4'h0;
          if (s_r.status == ST_HALT) begin
            s_nxt.st = S_IDLE;
            s_nxt.status = ST_PASSIVE;
            s_nxt.ad_oe = 1'b0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = S_T2;
            s_nxt.ad_out = s_r.write ? i_req_wdata : s_r.ad_out;
            s_nxt.ad_oe = s_r.write;
            s_nxt.rd_n = ~s_r.readlike;
            s_nxt.wr_n = ~s_r.write;
            s_nxt.den_n = ~(s_r.write | s_r.readlike);
          end
        end
        S_T2: begin
          s_nxt.st = S_T3;
          s_nxt.rdy_seen = 1'b0;
        end
        S_T3: begin
          // Wait states repeat T3 until a ready is seen
          if (s_r.rdy_seen || async_ready_s || i_ignore_ready) begin
            s_nxt.st = S_T4;
            s_nxt.status = ST_PASSIVE;
            s_nxt.rd_n = 1'b1;
            s_nxt.wr_n = 1'b1;
            s_nxt.rdata = s_r.readlike ? ad_s : s_r.rdata;
            s_nxt.done = 1'b1;
          end
        end
        S_T4: begin
          s_nxt.st = S_IDLE;
          s_nxt.den_n = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.lock = s_r.lock & i_req_lock;
        end
        S_HOLD: begin
          if (!hold_s) begin
            s_nxt.st = S_IDLE;
            s_nxt.grant = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '{st: S_IDLE, strap_cnt: 2'h0, mode_done: 1'b0, qmode: 1'b0, ale: 1'b0,
        rd_n: 1'b1, wr_n: 1'b1, den_n: 1'b1, lock: 1'b0, status: ST_PASSIVE,
        ad_out: 16'h0000, ad_oe: 1'b0, ahi: 4'h0, ube_n: 1'b1, qs: QS_NONE,
        rdy_seen: 1'b0, grant: 1'b0, done: 1'b0, rdata: 16'h0000, write: 1'b0,
        readlike: 1'b0, refresh: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign o_done = s_r.done;
  assign o_rdata = s_r.rdata;
  assign o_queue_mode = s_r.qmode;
  assign o_ad_out = s_r.ad_out;
  assign o_ad_oe = s_r.ad_oe && !s_r.grant;
  assign o_addr_hi = s_r.ahi;
  assign o_addr_hi_oe = s_r.mode_done && !s_r.grant;
  assign o_bus_cycle_status = s_r.status;
  assign o_status_oe = s_r.mode_done && !s_r.grant;
  assign o_ale_queue_state_low = s_r.qmode ? s_r.qs[0] : s_r.ale;
  assign o_wr_n_queue_state_high = s_r.qmode ? s_r.qs[1] : s_r.wr_n;
  assign o_wr_oe = s_r.mode_done && (s_r.qmode || !s_r.grant);
  assign o_rd_n = s_r.rd_n;
  // Read pin stays an input until the strap has been taken
  assign o_rd_oe = s_r.mode_done && !s_r.grant;
  assign o_upper_byte_enable_n = s_r.ube_n;
  assign o_ube_oe = s_r.mode_done && !s_r.grant;
  assign o_transceiver_data_enable_n = s_r.den_n;
  assign o_den_oe = !s_r.grant;
  assign o_lock_n = ~s_r.lock;
  // Lock pin floats in reset so the weak pull-up holds it high
  assign o_lock_oe = s_r.mode_done && !s_r.grant;
  assign o_bus_grant_ack = s_r.grant;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_passive_idle;
    (s_r.st == S_IDLE) |-> (s_r.status == ST_PASSIVE);
  endproperty
  a_passive_idle: assert property (p_passive_idle) else $error("status not passive when idle");

  property p_ale_pulse;
    $rose(s_r.ale) |-> (s_r.st == S_T1) ##1 !s_r.ale;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe not one cycle");

  property p_qs_pins;
    s_r.qmode && (i_queue_op == Q_OP_NEXT) |=> o_ale_queue_state_low && o_wr_n_queue_state_high;
  endproperty
  a_qs_pins: assert property (p_qs_pins) else $error("queue status pins wrong");

  property p_qs_empty;
    (i_queue_op == Q_OP_EMPTY) |=> (s_r.qs == QS_EMPTY);
  endproperty
  a_qs_empty: assert property (p_qs_empty) else $error("queue empty code wrong");

  property p_rd_bus_free;
    !o_rd_n |-> s_r.readlike && !o_ad_oe && (s_r.st inside {S_T2, S_T3});
  endproperty
  a_rd_bus_free: assert property (p_rd_bus_free) else $error("read strobe with bus driven");

  property p_wr_data;
    !s_r.wr_n |-> s_r.write && s_r.ad_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write strobe without data");

  property p_den_window;
    !s_r.den_n |-> (s_r.st inside {S_T2, S_T3, S_T4});
  endproperty
  a_den_window: assert property (p_den_window) else $error("data enable outside data phase");

  property p_wait_ready;
    rise && (s_r.st == S_T3) && !s_r.rdy_seen && !async_ready_s && !i_ignore_ready |=> (s_r.st == S_T3);
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("cycle ended without ready");

  property p_lock_hold;
    s_r.lock |=> !$rose(s_r.grant);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("hold granted under lock");

  property p_refresh8;
    !i_bus16 && (s_r.st == S_T2) |-> (o_upper_byte_enable_n == !s_r.refresh);
  endproperty
  a_refresh8: assert property (p_refresh8) else $error("refresh indicator wrong");

  property p_float_grant;
    s_r.grant |-> !o_status_oe && !o_rd_oe && !o_ube_oe;
  endproperty
  a_float_grant: assert property (p_float_grant) else $error("pins driven while granted");
endmodule // lbsc_bus_ctrl

// *** rtl/lbsc_clk_div.sv ***
// Bus clock divider: half rate output plus phase enables.
// Assumes i_clk is the input clock; bus clock toggles every cycle.
`timescale 1ns/1ps
module lbsc_clk_div import lbsc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  output logic o_bus_clock_out,
  output logic o_rise_en,
  output logic o_fall_en
);
  typedef struct packed {
    logic clk;
  } div_t;
  div_t d_r;
  div_t d_nxt;

  always_comb begin
    d_nxt.clk = ~d_r.clk;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      d_r <= BUS_CLK_RST;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign o_bus_clock_out = d_r.clk;
  // Enables mark the edge at which the bus clock next rises or falls
  assign o_rise_en = ~d_r.clk;
  assign o_fall_en = d_r.clk;

  property p_toggle;
    @(posedge i_clk) disable iff (!i_rstn)
    i_rstn |=> o_bus_clock_out != $past(o_bus_clock_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("bus clock did not toggle");
endmodule // lbsc_clk_div

// *** rtl/lbsc_pkg.sv ***
// Constants and types for the local bus status and control block.
// Assumes one 10 MHz clock and an active-low asynchronous reset.
// ----------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------
package lbsc_pkg;
  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ST_INTA = 3'h0;
  localparam logic [2:0] ST_IO_RD = 3'h1;
  localparam logic [2:0] ST_IO_WR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MEM_RD = 3'h5;
  localparam logic [2:0] ST_MEM_WR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;
  // ----------------------------------------------------------------
  // Queue status codes, {high, low}
  // ----------------------------------------------------------------
  localparam logic [1:0] QS_NONE = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_NEXT = 2'h3;
  localparam logic [1:0] QS_EMPTY = 2'h2;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic STRAP_RST = 1'b1;
  localparam logic LINE_RST = 1'b0;
  localparam logic BUS_CLK_RST = 1'b0;
  localparam int AD_W = 16;
  localparam int AHI_W = 4;

  typedef enum logic [1:0] {Q_OP_NONE, Q_OP_FIRST, Q_OP_NEXT, Q_OP_EMPTY} queue_op_t;
  typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_T3, S_T4, S_HOLD} bus_state_t;
endpackage

// *** rtl/lbsc_sync2.sv ***
// Two-stage synchroniser for pin inputs, one stage pair per bit.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module lbsc_sync2 import lbsc_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } sync_t;
  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt.meta = i_d;
    s_nxt.out = s_r.meta;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= {RST, RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.out;
endmodule // lbsc_sync2

// *** tb/lbsc_mem_model.sv ***
// Memory and I/O device model on the far side of the local bus.
// Assumes active-low strobes, sampled on rising i_clk edges.
`timescale 1ns/1ps
module lbsc_mem_model #(
  parameter logic [15:0] RD_DATA = 16'hc3a5
) (
  input wire logic i_clk,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [15:0] i_ad_out,
  input wire logic [3:0] i_wait,
  input wire logic i_stall,
  output logic [15:0] o_ad_in,
  output logic o_ready,
  output logic [15:0] o_wdata
);
  logic [3:0] cnt_r;
  logic [15:0] addr_r;
  // ----------------------------------------------------------------
  // Data and ready
  // ----------------------------------------------------------------
  initial begin
    o_ad_in = 16'h0;
    o_wdata = 16'h0;
    cnt_r = 4'h0;
    addr_r = 16'h0;
  end
  always @(posedge i_clk) begin
    // Read word carries the address, so a stale word cannot pass
    if (i_rd_n && i_wr_n) begin
      addr_r <= i_ad_out;
    end
    if (!i_rd_n) begin
      o_ad_in <= RD_DATA ^ addr_r;
    end else begin
      // Released bus keeps moving so stale data never looks valid
      o_ad_in <= ~o_ad_in;
    end
    if (!i_wr_n) begin
      o_wdata <= i_ad_out;
    end
    cnt_r <= (i_rd_n && i_wr_n) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hf};
  end
  assign o_ready = !(i_rd_n && i_wr_n) && !i_stall && (cnt_r >= i_wait);
endmodule // lbsc_mem_model

// *** tb/local_bus_status_control_tb.sv ***
// Self-checking bench for the local bus status and control block.
// Assumes lbsc_pkg, lbsc_bus_ctrl and the device model are compiled first.
`timescale 1ns/1ps
module local_bus_status_control_tb;
  import lbsc_pkg::*;
  typedef struct packed {
    logic [2:0] st;
    logic [19:0] addr;
    logic word;
    logic refresh_indicator_n;
    logic b16;
    logic asy;
    logic ube;
  } row_t;
  localparam logic [15:0] RD = 16'hc3a5;
  logic i_clk = 1'b0, i_rstn, i_req, i_req_word, i_req_refresh, i_req_lock, i_bus16, i_ignore_ready;
  logic i_instr_boundary, i_hold, i_rd_queue_mode_select, use_async, stall, rdy, b;
  logic [2:0] i_req_status;
  logic [19:0] i_req_addr;
  logic [15:0] i_req_wdata, ad_in, wcap, o_rdata, o_ad_out;
  queue_op_t i_queue_op;
  logic o_req_ready, o_done, o_queue_mode, o_ad_oe, o_addr_hi_oe, o_status_oe, o_ale_queue_state_low;
  logic o_wr_n_queue_state_high, o_wr_oe, o_rd_n, o_rd_oe, o_upper_byte_enable_n, o_ube_oe;
  logic o_transceiver_data_enable_n, o_den_oe, o_lock_n, o_lock_oe, o_bus_grant_ack, o_bus_clock_out;
  logic [3:0] o_addr_hi;
  logic [2:0] o_bus_cycle_status;
  logic [1:0] qexp [4] = '{QS_NONE, QS_FIRST, QS_NEXT, QS_EMPTY};
  int error_cnt = 0, checks_done = 0;
  row_t rows [8] = '{
    '{ST_INTA, 20'h12340, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{ST_IO_RD, 20'h00031, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
    '{ST_IO_WR, 20'h00052, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1},
    '{ST_HALT, 20'h00000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
    '{ST_FETCH, 20'hfff00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{ST_MEM_RD, 20'h80a00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
    '{ST_MEM_WR, 20'h8b201, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
    '{ST_MEM_RD, 20'h00010, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}};

  always #50 i_clk = ~i_clk;

  lbsc_bus_ctrl u_lbsc_bus_ctrl (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_req_status(i_req_status),
    .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_req_word(i_req_word), .i_req_refresh(i_req_refresh),
    .i_req_lock(i_req_lock), .i_bus16(i_bus16), .i_ignore_ready(i_ignore_ready),
    .i_instr_boundary(i_instr_boundary), .i_queue_op(i_queue_op), .o_req_ready(o_req_ready), .o_done(o_done),
    .o_rdata(o_rdata), .o_queue_mode(o_queue_mode), .i_async_ready(rdy & use_async),
    .i_sync_ready(rdy & !use_async), .i_hold(i_hold), .i_ad_in(ad_in), .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe),
    .o_addr_hi(o_addr_hi), .o_addr_hi_oe(o_addr_hi_oe), .o_bus_cycle_status(o_bus_cycle_status),
    .o_status_oe(o_status_oe), .o_ale_queue_state_low(o_ale_queue_state_low),
    .o_wr_n_queue_state_high(o_wr_n_queue_state_high), .o_wr_oe(o_wr_oe),
    .i_rd_queue_mode_select(i_rd_queue_mode_select), .o_rd_n(o_rd_n), .o_rd_oe(o_rd_oe),
    .o_upper_byte_enable_n(o_upper_byte_enable_n), .o_ube_oe(o_ube_oe),
    .o_transceiver_data_enable_n(o_transceiver_data_enable_n), .o_den_oe(o_den_oe), .o_lock_n(o_lock_n),
    .o_lock_oe(o_lock_oe), .o_bus_grant_ack(o_bus_grant_ack), .o_bus_clock_out(o_bus_clock_out));

  lbsc_mem_model u_lbsc_mem_model (.i_clk(i_clk), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n_queue_state_high),
    .i_ad_out(o_ad_out), .i_wait(4'h1), .i_stall(stall), .o_ad_in(ad_in), .o_ready(rdy), .o_wdata(wcap));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: probe = o_ale_queue_state_low;
      1: probe = o_done;
      2: probe = o_bus_grant_ack;
      3: probe = !o_rd_n;
      4: probe = !o_wr_n_queue_state_high;
      default: probe = o_req_ready;
    endcase
  endfunction
  // Bounded wait at falling edges; a hang ends the run
  task automatic wait_hi(input int sel, input logic lvl);
    int n;
    n = 0;
    while (probe(sel) !== lvl) begin
      @(negedge i_clk);
      n++;
      if (n > 80) begin
        chk(20'h1, 20'h0);
        summarize();
      end
    end
  endtask
  task automatic issue(input row_t r);
    @(posedge i_clk);
    i_req_status <= r.st;
    i_req_addr <= r.addr;
    i_req_wdata <= r.addr[15:0] ^ 16'h0f0f;
    i_req_word <= r.word;
    i_req_refresh <= r.refresh_indicator_n;
    i_bus16 <= r.b16;
    use_async <= r.asy;
    i_req <= 1'b1;
    @(negedge i_clk);
    wait_hi(5, 1'b1);
    @(posedge i_clk);
    i_req <= 1'b0;
  endtask
  task automatic run(input row_t r);
    logic wr;
    logic [15:0] ea;
    wr = (r.st == ST_IO_WR) || (r.st == ST_MEM_WR);
    ea = {r.addr[15:1], r.addr[0] | (r.refresh_indicator_n & r.b16)};
    issue(r);
    wait_hi(0, 1'b1);
    chk(o_bus_cycle_status, r.st);
    chk(o_ad_out, ea);
    chk({o_addr_hi, o_ad_oe}, {r.addr[19:16], 1'b1});
    chk(o_transceiver_data_enable_n, 1'b1);
    if (r.st != ST_HALT) begin
      chk(o_upper_byte_enable_n, r.ube);
      wait_hi(wr ? 4 : 3, 1'b1);
      chk(o_ale_queue_state_low, 1'b0);
      chk(o_transceiver_data_enable_n, 1'b0);
      chk({o_addr_hi, o_ad_oe}, {4'h0, wr});
    end
    wait_hi(1, 1'b1);
    if (r.st != ST_HALT) begin
      chk(o_bus_cycle_status, ST_PASSIVE);
    end
    @(negedge i_clk);
    if (wr) begin
      chk(wcap, r.addr[15:0] ^ 16'h0f0f);
    end else if (r.st != ST_HALT) begin
      chk(o_rdata, RD ^ ea);
    end
  endtask
  task automatic reset_chk;
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(o_bus_cycle_status, ST_PASSIVE);
    chk({o_status_oe, o_rd_oe, o_wr_oe, o_lock_oe, o_ale_queue_state_low}, 5'h0);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rstn, i_req, i_req_word, i_req_refresh, i_req_lock, i_bus16, i_ignore_ready} = 7'h0;
    {i_instr_boundary, i_hold, use_async, stall} = 4'h0;
    i_rd_queue_mode_select = 1'b1;
    i_req_status = ST_PASSIVE;
    i_req_addr = 20'h0;
    i_req_wdata = 16'h0;
    i_queue_op = Q_OP_NONE;
    reset_chk();
    chk(o_queue_mode, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(negedge i_clk);
      b = o_bus_clock_out;
      @(negedge i_clk);
      chk(o_bus_clock_out, !b);
    end
    foreach (rows[i]) begin
      run(rows[i]);
    end
    // No ready: cycle must stall, then end once ready arrives
    @(posedge i_clk);
    stall <= 1'b1;
    issue(rows[5]);
    wait_hi(3, 1'b1);
    repeat (20) begin
      @(negedge i_clk);
      chk(o_done, 1'b0);
    end
    @(posedge i_clk);
    stall <= 1'b0;
    wait_hi(1, 1'b1);
    // Ready ignored ends the cycle with the model silent
    @(posedge i_clk);
    stall <= 1'b1;
    i_ignore_ready <= 1'b1;
    run(rows[1]);
    @(posedge i_clk);
    i_ignore_ready <= 1'b0;
    stall <= 1'b0;
    i_req_lock <= 1'b1;
    // Lock kept past the cycle end: hold at a boundary must still wait
    issue(rows[4]);
    i_hold <= 1'b1;
    i_instr_boundary <= 1'b1;
    wait_hi(0, 1'b1);
    chk(o_lock_n, 1'b0);
    wait_hi(1, 1'b1);
    repeat (8) begin
      @(negedge i_clk);
      chk({o_lock_n, o_bus_grant_ack}, 2'h0);
    end
    @(posedge i_clk);
    i_req_lock <= 1'b0;
    i_instr_boundary <= 1'b0;
    // Unlocked cycle clears the lock; no boundary, so still no grant
    run(rows[1]);
    repeat (10) begin
      @(negedge i_clk);
      chk(o_bus_grant_ack, 1'b0);
    end
    @(posedge i_clk);
    i_instr_boundary <= 1'b1;
    wait_hi(2, 1'b1);
    chk({o_status_oe, o_rd_oe, o_wr_oe, o_ube_oe}, 4'h0);
    chk({o_ad_oe, o_addr_hi_oe, o_den_oe, o_lock_oe}, 4'h0);
    @(posedge i_clk);
    i_hold <= 1'b0;
    wait_hi(2, 1'b0);
    // Queue status mode strapped through the read pin
    @(posedge i_clk);
    i_rd_queue_mode_select <= 1'b0;
    reset_chk();
    chk(o_queue_mode, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_queue_op <= queue_op_t'(k);
      @(posedge i_clk);
      @(negedge i_clk);
      chk({o_wr_n_queue_state_high, o_ale_queue_state_low}, qexp[k]);
    end
    summarize();
  end
endmodule // local_bus_status_control_tb
